// ===== rtl/apss_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - per-entry gain one, two, four or eight
// - one polarity; some variants bipolar only
// - internal 24-bit pacer or external clock
// - pacer runs from 20 MHz time base
// - pacer pulse active low, falling edge starts
// - pacer reaches down to 1.2 Hz
// - variant-dependent maximum internal pacing rate
// - single-entry digital-only list allows 3 MHz pacing
// - sample clock also paces digital capture
// - external clock falling edge starts conversion
// - external rate followed directly, no division
// - single conversion ignores clock and scan settings
// - single conversion self-ends, not stoppable
// - orderly stop finishes conversion, delivers, ignores triggers
// - abrupt stop halts, discards, ignores triggers
// - scan list in order and wrap
// - one conversion per sample clock tick
// - continuous scan only; burst bit stored and read back, no effect
// - list up to 1024 entries, channel and gain
// - inhibit flag discards the converted value
// - channel sixteen captures digital lines
module apss_sequencer #(
   parameter int LIST_DEPTH = 1024,
   parameter int DATA_W     = 16,
   parameter int VARIANT    = 0,
   parameter bit UNIPOLAR_OK = 1'b1
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic [11:0]       addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic [31:0]            rdata,
   input  wire logic              tb_tick,
   input  wire logic              ext_clk_in,
   output logic                   pacer_out_n,
   output logic                   conv_start,
   output logic [4:0]             conv_chan,
   output logic [1:0]             conv_gain,
   output logic                   conv_bipolar,
   input  wire logic              conv_done,
   input  wire logic [DATA_W-1:0] conv_data,
   input  wire logic [15:0]       dig_lines,
   output logic                   sample_valid,
   output logic [DATA_W-1:0]      sample_data,
   output logic [4:0]             sample_chan,
   output logic                   busy
);
   localparam int PW = $clog2(LIST_DEPTH);

   // refuse sizes the list pointer and data path cannot serve
   if (LIST_DEPTH < 2 || LIST_DEPTH > 1024) begin : g_bad_depth
      $error("apss_sequencer: LIST_DEPTH out of range");
   end
   if (DATA_W < 16 || DATA_W > 32) begin : g_bad_width
      $error("apss_sequencer: DATA_W out of range");
   end
   if (VARIANT < 0 || VARIANT > 2) begin : g_bad_variant
      $error("apss_sequencer: VARIANT out of range");
   end

   localparam int MIN_DIV = (VARIANT == 1) ? apss_pkg::MIN_DIV_V1 :
                            (VARIANT == 2) ? apss_pkg::MIN_DIV_V2 : apss_pkg::MIN_DIV_V0;

   logic [7:0]             list_mem [LIST_DEPTH];
   logic                   bipolar_reg;
   logic                   ext_clk_reg;
   logic                   burst_reg;
   logic [23:0]            divisor_reg;
   logic [23:0]            count_reg;
   logic [PW:0]            list_len_reg;
   logic [PW-1:0]          ptr_reg;
   logic [31:0]            samples_reg;
   logic [31:0]            taken_reg;
   apss_pkg::apss_state_e  state_reg;
   logic                   ext_prev_reg;
   logic                   single_pend_reg;
   logic                   single_busy_reg;
   logic [4:0]             single_chan_reg;
   logic [1:0]             single_gain_reg;
   logic [DATA_W-1:0]      single_data_reg;
   logic                   single_done_reg;
   logic                   in_conv_reg;
   logic                   dig_only;
   logic [23:0]            div_eff;
   logic                   tick;
   logic                   scan_tick;
   logic [7:0]             cur_ent;
   logic                   ctrl_wr;

   // decoded control strobes and shared decodes
   logic                   start_req;
   logic                   abrupt_req;
   logic                   orderly_req;
   logic                   conv_abort;
   logic                   list_hit;
   logic [PW-1:0]          list_idx;
   logic                   len_one;
   logic                   head_dig;
   logic                   ext_fall;
   logic                   pacer_tc;
   logic                   ptr_wrap;
   logic                   count_hit;
   logic [31:0]            taken_next;
   logic [31:0]            ctrl_word;
   logic [31:0]            status_word;
   logic [31:0]            rd_mux;

   assign ctrl_wr = wr && addr == apss_pkg::ADDR_CTRL;
   assign cur_ent = list_mem[ptr_reg];

   // control strobes taken from a control-register write
   assign start_req   = ctrl_wr && wdata[apss_pkg::CTRL_START];
   assign abrupt_req  = ctrl_wr && wdata[apss_pkg::CTRL_ABRUPT];
   assign orderly_req = ctrl_wr && wdata[apss_pkg::CTRL_ORDERLY];

   // list window shared by the write and read paths
   assign list_hit = addr >= apss_pkg::ADDR_LIST_LO &&
                     (addr - apss_pkg::ADDR_LIST_LO) < 12'(LIST_DEPTH);
   assign list_idx = PW'(addr - apss_pkg::ADDR_LIST_LO);
   assign len_one  = list_len_reg == (PW+1)'(1);
   assign head_dig = list_mem[0][4:0] == apss_pkg::DIGITAL_CHAN;
   assign dig_only = len_one && head_dig;

   assign ctrl_word   = {26'h0, burst_reg, 3'h0, ext_clk_reg, bipolar_reg};
   assign status_word = {28'h0, single_done_reg, single_busy_reg, state_reg};

   // divisor clamped to fastest allowed rate; 24 bits covers 1.2 Hz
   always_comb begin
      if (dig_only && divisor_reg < 24'(apss_pkg::MIN_DIV_DIG))
         div_eff = 24'(apss_pkg::MIN_DIV_DIG);
      else if (!dig_only && divisor_reg < 24'(MIN_DIV))
         div_eff = 24'(MIN_DIV);
      else
         div_eff = divisor_reg;
   end

   // configuration registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         bipolar_reg  <= 1'b1;
         ext_clk_reg  <= 1'b0;
         burst_reg    <= 1'b0;
         divisor_reg  <= apss_pkg::DIV_RESET;
         list_len_reg <= (PW+1)'(1);
         samples_reg  <= apss_pkg::SAMPLES_RESET;
      end else if (wr && state_reg != apss_pkg::APSS_RUN) begin
         unique case (addr)
            apss_pkg::ADDR_CTRL: begin
               bipolar_reg <= wdata[apss_pkg::CTRL_BIPOLAR] | ~UNIPOLAR_OK;
               ext_clk_reg <= wdata[apss_pkg::CTRL_EXT_CLK];
               burst_reg   <= wdata[apss_pkg::CTRL_BURST];
            end
            apss_pkg::ADDR_DIVISOR: begin
               divisor_reg <= wdata[23:0];
            end
            // zero or over-deep lengths are refused
            apss_pkg::ADDR_LIST_LEN: begin
               if (wdata[PW:0] != '0 && wdata[PW:0] <= (PW+1)'(LIST_DEPTH))
                  list_len_reg <= wdata[PW:0];
            end
            apss_pkg::ADDR_SAMPLES: begin
               samples_reg <= wdata;
            end
            default: ;
         endcase
      end
   end

   // channel list: channel, gain, inhibit per entry
   always_ff @(posedge mclk) begin
      if (wr && list_hit && state_reg != apss_pkg::APSS_RUN)
         list_mem[list_idx] <= wdata[7:0];
   end

   // internal pacer: 20 MHz time base enable, reload at terminal count
   always_ff @(posedge mclk) begin
      if (rst || state_reg != apss_pkg::APSS_RUN) begin
         count_reg   <= 24'h000000;
         pacer_out_n <= 1'b1;
      end else if (tb_tick) begin
         if (pacer_tc) begin
            count_reg   <= div_eff - 24'h000001;
            pacer_out_n <= 1'b0;
         end else begin
            count_reg   <= count_reg - 24'h000001;
            pacer_out_n <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst)
         ext_prev_reg <= 1'b1;
      else
         ext_prev_reg <= ext_clk_in;
   end

   // falling edge of the selected source
   assign ext_fall  = ext_prev_reg && !ext_clk_in;
   assign pacer_tc  = tb_tick && count_reg == 24'h000000;
   assign tick      = ext_clk_reg ? ext_fall
                                  : (pacer_tc && state_reg == apss_pkg::APSS_RUN);

   // a tick landing on an abrupt stop is dropped with the stop
   assign scan_tick = tick && state_reg == apss_pkg::APSS_RUN && !in_conv_reg &&
                      !abrupt_req;
   assign conv_abort = state_reg == apss_pkg::APSS_RUN && abrupt_req && !single_busy_reg;
   assign taken_next = taken_reg + 32'h00000001;
   assign count_hit  = samples_reg != 32'h00000000 && taken_next >= samples_reg;
   assign ptr_wrap   = (PW+1)'(ptr_reg) + (PW+1)'(1) >= list_len_reg;

   // scan state machine
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= apss_pkg::APSS_IDLE;
         ptr_reg   <= '0;
         taken_reg <= 32'h00000000;
      end else begin
         unique case (state_reg)
            apss_pkg::APSS_IDLE, apss_pkg::APSS_STOPPED:
               if (start_req && !single_busy_reg && !single_pend_reg) begin
                  state_reg <= apss_pkg::APSS_RUN;
                  ptr_reg   <= '0;
                  taken_reg <= 32'h00000000;
               end
            apss_pkg::APSS_RUN: begin
               if (abrupt_req)
                  state_reg <= apss_pkg::APSS_STOPPED;
               else if (orderly_req)
                  state_reg <= apss_pkg::APSS_DRAIN;
               else if (conv_done && in_conv_reg) begin
                  taken_reg <= taken_next;
                  if (count_hit)
                     state_reg <= apss_pkg::APSS_STOPPED;
               end
               if (scan_tick) begin
                  if (ptr_wrap)
                     ptr_reg <= '0;
                  else
                     ptr_reg <= ptr_reg + PW'(1);
               end
            end
            apss_pkg::APSS_DRAIN:
               if (abrupt_req)
                  state_reg <= apss_pkg::APSS_STOPPED;
               else if (!in_conv_reg || conv_done)
                  state_reg <= apss_pkg::APSS_STOPPED;
         endcase
      end
   end

   // conversion launch; single conversion has priority when idle
   always_ff @(posedge mclk) begin
      if (rst) begin
         in_conv_reg     <= 1'b0;
         conv_start      <= 1'b0;
         conv_chan       <= 5'h00;
         conv_gain       <= 2'h0;
         single_busy_reg <= 1'b0;
         single_pend_reg <= 1'b0;
         single_chan_reg <= 5'h00;
         single_gain_reg <= 2'h0;
      end else begin
         conv_start <= 1'b0;
         if (wr && addr == apss_pkg::ADDR_SINGLE && state_reg != apss_pkg::APSS_RUN &&
             !single_busy_reg) begin
            single_pend_reg <= 1'b1;
            single_chan_reg <= wdata[4:0];
            single_gain_reg <= wdata[6:5];
         end
         if (single_pend_reg && !in_conv_reg) begin
            single_pend_reg <= 1'b0;
            single_busy_reg <= 1'b1;
            in_conv_reg     <= 1'b1;
            conv_start      <= 1'b1;
            conv_chan       <= single_chan_reg;
            conv_gain       <= single_gain_reg;
         end else if (scan_tick) begin
            in_conv_reg <= 1'b1;
            conv_start  <= 1'b1;
            conv_chan   <= cur_ent[4:0];
            conv_gain   <= cur_ent[6:5];
         end else if (in_conv_reg && (conv_done || conv_abort)) begin
            in_conv_reg     <= 1'b0;
            single_busy_reg <= 1'b0;
         end
      end
   end

   // result path: digital capture, inhibit, abrupt discard
   logic [4:0] res_chan_reg;
   logic       res_inh_reg;
   logic [DATA_W-1:0] res_word;
   logic [DATA_W-1:0] single_word;

   // digital pseudo channel takes the sixteen lines in place of the converted data
   assign res_word    = (res_chan_reg == apss_pkg::DIGITAL_CHAN) ? DATA_W'(dig_lines)
                                                                  : conv_data;
   assign single_word = (single_chan_reg == apss_pkg::DIGITAL_CHAN) ? DATA_W'(dig_lines)
                                                                     : conv_data;

   always_ff @(posedge mclk) begin
      if (rst) begin
         res_chan_reg    <= 5'h00;
         res_inh_reg     <= 1'b0;
         sample_valid    <= 1'b0;
         sample_data     <= '0;
         sample_chan     <= 5'h00;
         single_data_reg <= '0;
         single_done_reg <= 1'b0;
      end else begin
         sample_valid <= 1'b0;
         if (scan_tick && !(single_pend_reg)) begin
            res_chan_reg <= cur_ent[4:0];
            res_inh_reg  <= cur_ent[apss_pkg::ENT_INHIBIT];
         end
         if (start_req)
            single_done_reg <= 1'b0;
         if (in_conv_reg && conv_done) begin
            if (single_busy_reg) begin
               single_data_reg <= single_word;
               single_done_reg <= 1'b1;
            end else if (state_reg != apss_pkg::APSS_STOPPED && !res_inh_reg) begin
               sample_valid <= 1'b1;
               sample_chan  <= res_chan_reg;
               sample_data  <= res_word;
            end
         end
      end
   end

   assign conv_bipolar = bipolar_reg;
   assign busy = state_reg == apss_pkg::APSS_RUN || state_reg == apss_pkg::APSS_DRAIN ||
                 single_busy_reg;

   // read mux; unmapped addresses read as zero
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (addr)
         apss_pkg::ADDR_CTRL:     rd_mux = ctrl_word;
         apss_pkg::ADDR_STATUS:   rd_mux = status_word;
         apss_pkg::ADDR_DIVISOR:  rd_mux = {8'h00, divisor_reg};
         apss_pkg::ADDR_LIST_LEN: rd_mux = 32'(list_len_reg);
         apss_pkg::ADDR_SAMPLES:  rd_mux = taken_reg;
         apss_pkg::ADDR_SINGLE:   rd_mux = 32'(single_data_reg);
         apss_pkg::ADDR_VARIANT:  rd_mux = {30'h0, 2'(VARIANT)};
         default: begin
            if (list_hit)
               rd_mux = {24'h0, list_mem[list_idx]};
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (rst)
         rdata <= 32'h00000000;
      else if (rd)
         rdata <= rd_mux;
      else
         rdata <= 32'h00000000;
   end
endmodule

// ===== rtl/apss_pkg.sv
package apss_pkg;
   // register offsets (word addresses on the plain port)
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_STATUS   = 12'h001;
   localparam logic [11:0] ADDR_DIVISOR  = 12'h002;
   localparam logic [11:0] ADDR_LIST_LEN = 12'h003;
   localparam logic [11:0] ADDR_SAMPLES  = 12'h004;
   localparam logic [11:0] ADDR_SINGLE   = 12'h005;
   localparam logic [11:0] ADDR_DATA     = 12'h006;
   localparam logic [11:0] ADDR_VARIANT  = 12'h007;
   localparam logic [11:0] ADDR_LIST_LO  = 12'h400;
   // control field positions
   localparam int CTRL_BIPOLAR  = 0;
   localparam int CTRL_EXT_CLK  = 1;
   localparam int CTRL_START    = 2;
   localparam int CTRL_ORDERLY  = 3;
   localparam int CTRL_ABRUPT   = 4;
   localparam int CTRL_BURST    = 5;
   // list entry field positions
   localparam int ENT_CHAN_LSB  = 0;
   localparam int ENT_GAIN_LSB  = 5;
   localparam int ENT_INHIBIT   = 7;
   localparam logic [4:0] DIGITAL_CHAN = 5'h10;
   // gain codes: 0=x1 1=x2 2=x4 3=x8
   localparam logic [1:0] GAIN_UNITY = 2'h0;
   // timing
   localparam int TIMEBASE_HZ   = 20000000;
   localparam int MIN_RATE_MHZ  = 1200;          // 1.2 Hz in mHz
   localparam int MAX_DIG_HZ    = 3000000;
   localparam int MAX_RATE_HZ_V0 = 225000;
   localparam int MAX_RATE_HZ_V1 = 400000;
   localparam int MAX_RATE_HZ_V2 = 250000;
   localparam int MIN_DIV_DIG   = TIMEBASE_HZ / MAX_DIG_HZ + 1;
   localparam int MIN_DIV_V0    = (TIMEBASE_HZ + MAX_RATE_HZ_V0 - 1) / MAX_RATE_HZ_V0;
   localparam int MIN_DIV_V1    = TIMEBASE_HZ / MAX_RATE_HZ_V1;
   localparam int MIN_DIV_V2    = TIMEBASE_HZ / MAX_RATE_HZ_V2;
   localparam logic [23:0] DIV_RESET = 24'h00FFFF;
   localparam logic [31:0] SAMPLES_RESET = 32'h00000000;
   typedef enum logic [1:0] {APSS_IDLE, APSS_RUN, APSS_DRAIN, APSS_STOPPED} apss_state_e;
endpackage

// ===== tb/apss_conv_model.sv
`timescale 1ns/1ps
module apss_conv_model (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        conv_start,
   input  wire logic [4:0]  conv_chan,
   input  wire logic [1:0]  conv_gain,
   input  wire logic [4:0]  lat,
   output logic             conv_done,
   output logic [15:0]      conv_data
);
   logic [4:0]  cnt;
   logic [15:0] held;
   // answers lat cycles after a start; data is scrambled outside the done cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt       <= 5'h00;
         held      <= 16'h0000;
         conv_done <= 1'b0;
         conv_data <= 16'h0000;
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         if (conv_start) begin
            cnt  <= lat;
            held <= {6'h00, conv_gain, 3'h0, conv_chan};
         end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
            if (cnt == 5'h01) begin
               conv_done <= 1'b1;
               conv_data <= held;
            end
         end
      end
   end
endmodule

// ===== tb/apss_sequencer_chk.sv
`timescale 1ns/1ps
module apss_sequencer_chk #(
   parameter int DATA_W = 16
) (
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic              pacer_out_n,
   input wire logic              conv_start,
   input wire logic [4:0]        conv_chan,
   input wire logic [1:0]        conv_gain,
   input wire logic              conv_done,
   input wire logic [DATA_W-1:0] conv_data,
   input wire logic              sample_valid,
   input wire logic [DATA_W-1:0] sample_data,
   input wire logic [4:0]        sample_chan,
   input wire logic              busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_one_start;
      conv_start ##1 !conv_start;
   endsequence
   property p_pacer_pulse;
      !pacer_out_n |=> pacer_out_n;
   endproperty
   property p_start_pulse;
      conv_start |-> s_one_start;
   endproperty
   property p_start_busy;
      conv_start |-> busy;
   endproperty
   property p_valid_done;
      sample_valid |-> $past(conv_done);
   endproperty
   property p_valid_busy;
      sample_valid |-> $past(busy);
   endproperty
   property p_analog_data;
      sample_valid && sample_chan != apss_pkg::DIGITAL_CHAN |-> sample_data == $past(conv_data);
   endproperty
   property p_chan_hold;
      !$stable(conv_chan) || !$stable(conv_gain) |-> conv_start;
   endproperty
   property p_chan_range;
      conv_start |-> conv_chan <= apss_pkg::DIGITAL_CHAN;
   endproperty
   a_pacer_pulse: assert property (p_pacer_pulse) else $error("pacer pulse too long");
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
   a_start_busy: assert property (p_start_busy) else $error("start while idle");
   a_valid_done: assert property (p_valid_done) else $error("sample without done");
   a_valid_busy: assert property (p_valid_busy) else $error("sample after stop");
   a_analog_data: assert property (p_analog_data) else $error("sample data wrong");
   a_chan_hold: assert property (p_chan_hold) else $error("entry changed early");
   a_chan_range: assert property (p_chan_range) else $error("channel out of range");
   c_sample: cover property (sample_valid);
endmodule
bind apss_sequencer apss_sequencer_chk #(.DATA_W(DATA_W)) i_chk (
   .mclk(mclk), .rst(rst), .pacer_out_n(pacer_out_n), .conv_start(conv_start),
   .conv_chan(conv_chan), .conv_gain(conv_gain), .conv_done(conv_done),
   .conv_data(conv_data), .sample_valid(sample_valid), .sample_data(sample_data),
   .sample_chan(sample_chan), .busy(busy));

// ===== tb/apss_sequencer_tb_top.sv
`timescale 1ns/1ps
module apss_sequencer_tb_top;
   logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tb_tick = 1'b1;
   logic        ext_clk_in = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h00000000;
   logic [15:0] dig_lines = 16'hA5C3;
   logic [4:0]  lat = 5'h14;
   logic [31:0] rdata, v, w;
   logic        pacer_out_n, conv_start, conv_bipolar, conv_done, sample_valid, busy;
   logic [4:0]  conv_chan, sample_chan;
   logic [1:0]  conv_gain;
   logic [15:0] conv_data, sample_data;
   logic [7:0]  lst [0:3];
   logic [31:0] sq [$];
   int          fail_count = 0, samples_checked = 0, cyc = 0, t_pl = 0, per = 0;
   int          n_st = 0, n_sv = 0, n_pl = 0;
   always #50 mclk = ~mclk;
   apss_sequencer i_dut (
      .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .tb_tick(tb_tick), .ext_clk_in(ext_clk_in), .pacer_out_n(pacer_out_n),
      .conv_start(conv_start), .conv_chan(conv_chan), .conv_gain(conv_gain),
      .conv_bipolar(conv_bipolar), .conv_done(conv_done), .conv_data(conv_data),
      .dig_lines(dig_lines), .sample_valid(sample_valid), .sample_data(sample_data),
      .sample_chan(sample_chan), .busy(busy));
   apss_conv_model i_conv (.mclk(mclk), .rst(rst), .conv_start(conv_start),
      .conv_chan(conv_chan), .conv_gain(conv_gain), .lat(lat), .conv_done(conv_done),
      .conv_data(conv_data));
   task close_out();
      if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (conv_start === 1'b1) n_st++;
      if (sample_valid === 1'b1) begin
         n_sv++;
         sq.push_back({11'h000, sample_chan, sample_data});
      end
      if (pacer_out_n === 1'b0) begin
         n_pl++;
         per = cyc - t_pl;
         t_pl = cyc;
      end
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [11:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task wait_ev(input int ns, input int nv, input int np);
      for (int k = 0; k < 3000 && (n_st < ns || n_sv < nv || n_pl < np); k++) @(posedge mclk);
      #1;
   endtask
   task wait_idle();
      for (int k = 0; k < 60 && busy !== 1'b0; k++) @(posedge mclk);
      #1 chk("busy", 32'h0, {31'h0, busy});
   endtask
   // sample word expected for a list entry: channel above data
   function logic [31:0] expv(input logic [7:0] e);
      expv = {11'h000, e[4:0], (e[4:0] == apss_pkg::DIGITAL_CHAN) ? dig_lines :
              {6'h00, e[6:5], 3'h0, e[4:0]}};
   endfunction
   task run(input logic [31:0] c, input logic [23:0] d, input int len);
      for (int i = 0; i < len; i++) wr_reg(apss_pkg::ADDR_LIST_LO + 12'(i), {24'h0, lst[i]});
      wr_reg(apss_pkg::ADDR_LIST_LEN, 32'(len));
      wr_reg(apss_pkg::ADDR_DIVISOR, {8'h00, d});
      wr_reg(apss_pkg::ADDR_SAMPLES, 32'h00000000);
      wr_reg(apss_pkg::ADDR_CTRL, c);
      sq.delete();
      n_st = 0;
      n_sv = 0;
      n_pl = 0;
      wr_reg(apss_pkg::ADDR_CTRL, c | 32'h00000004);
   endtask
   task stop_chk(input int b, input int extra);
      int s, v0;
      s = n_st;
      wait_ev(s + 1, 0, 0);
      v0 = n_sv;
      wr_reg(apss_pkg::ADDR_CTRL, 32'h1 << b);
      wait_idle();
      s = n_st;
      repeat (300) @(posedge mclk);
      chk("stop_starts", 32'(s), 32'(n_st));
      chk("stop_valid", 32'(v0 + extra), 32'(n_sv));
   endtask
   task t_single();
      wr_reg(apss_pkg::ADDR_SINGLE, 32'h00000066);
      wr_reg(apss_pkg::ADDR_CTRL, 32'h00000010);
      wait_idle();
      rd_reg(apss_pkg::ADDR_SINGLE, v);
      w = expv(8'h66);
      chk("single", {16'h0, w[15:0]}, {16'h0, v[15:0]});
      rd_reg(apss_pkg::ADDR_STATUS, v);
      chk("single_done", 32'h1, {31'h0, v[3]});
   endtask
   task t_scan();
      int ord [0:4];
      ord = '{0, 1, 3, 0, 1};
      lst = '{8'h01, 8'h10, 8'hA5, 8'h62};
      run(32'h00000000, 24'h000064, 4);
      wait_ev(0, 5, 3);
      for (int i = 0; i < 5; i++) chk("scan", expv(lst[ord[i]]), sq[i]);
      chk("unipolar", 32'h0, {31'h0, conv_bipolar});
      chk("period", 32'h1, {31'h0, per == 100 || per == 101});
      stop_chk(apss_pkg::CTRL_ABRUPT, 0);
   endtask
   task t_order();
      lat = 5'h14;
      lst[0] = 8'h03;
      lst[1] = 8'h24;
      run(32'h00000001, 24'h000064, 2);
      wait_ev(0, 3, 0);
      for (int i = 0; i < 3; i++) chk("order", expv(lst[i % 2]), sq[i]);
      chk("bipolar", 32'h1, {31'h0, conv_bipolar});
      stop_chk(apss_pkg::CTRL_ORDERLY, 1);
   endtask
   task t_ext();
      int gap [0:3];
      gap = '{5, 13, 7, 30};
      lat <= 5'h04;
      run(32'h00000002, 24'hFFFFFF, 2);
      for (int i = 0; i < 4; i++) begin
         repeat (gap[i]) @(posedge mclk);
         ext_clk_in <= 1'b0;
         repeat (2) @(posedge mclk);
         ext_clk_in <= 1'b1;
      end
      repeat (6) @(posedge mclk);
      chk("ext_starts", 32'h4, 32'(n_st));
      rd_reg(apss_pkg::ADDR_DIVISOR, v);
      chk("divisor", 32'h00FFFFFF, v);
      wr_reg(apss_pkg::ADDR_CTRL, 32'h00000010);
      wait_idle();
   endtask
   task t_rate();
      lst[0] = 8'h10;
      run(32'h00000000, 24'h000007, 1);
      wait_ev(0, 1, 3);
      chk("dig_rate", 32'h1, {31'h0, per < apss_pkg::MIN_DIV_V0 && per >= 7});
      chk("dig_data", expv(lst[0]), sq[0]);
      wr_reg(apss_pkg::ADDR_CTRL, 32'h00000010);
      wait_idle();
      lst[0] = 8'h01;
      run(32'h00000000, 24'h00000A, 1);
      wait_ev(0, 0, 3);
      chk("max_rate", 32'h1, {31'h0, per >= apss_pkg::MIN_DIV_V0});
      wr_reg(apss_pkg::ADDR_CTRL, 32'h00000010);
      wait_idle();
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      #1 chk("reset_out", 32'h12,
             {27'h0, pacer_out_n, conv_start, busy, conv_bipolar, sample_valid});
      t_single();
      t_scan();
      t_order();
      t_ext();
      t_rate();
      close_out();
   end
endmodule
